// ### core/serial_pkg.sv
// Purpose: shared constants and types for the asynchronous serial character path
// Assumes: 8-bit register port, one clock, synchronous active-high reset
// Notes:   register offsets, bit positions, reset values and frame timing are the numbers used by the core

package serial_pkg;

	// ****************************************************************
	// register port geometry and offsets
	// ****************************************************************
	localparam int         ADDR_W       = 3;
	localparam int         DATA_W       = 8;
	localparam logic [2:0] OFF_STATUS   = 3'h0;   // serial_status_reg
	localparam logic [2:0] OFF_DATA     = 3'h1;   // serial_data_reg
	localparam logic [2:0] OFF_CTRL_ONE = 3'h2;   // serial_ctrl_one
	localparam logic [2:0] OFF_CTRL_TWO = 3'h3;   // serial_ctrl_two
	localparam logic [2:0] OFF_TX_DIV   = 3'h4;   // tx_ext_prescale
	localparam logic [2:0] OFF_RX_DIV   = 3'h5;   // rx_ext_prescale

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int ST_TX_EMPTY  = 7;
	localparam int ST_TX_DONE   = 6;
	localparam int ST_RX_FULL   = 5;
	localparam int ST_OVERRUN   = 3;
	localparam int ST_BREAK     = 1;
	localparam int C1_RX_NINTH  = 7;
	localparam int C1_TX_NINTH  = 6;
	localparam int C1_WORD9     = 4;
	localparam int C2_EMPTY_IE  = 7;
	localparam int C2_DONE_IE   = 6;
	localparam int C2_FULL_IE   = 5;
	localparam int C2_TX_ON     = 3;
	localparam int C2_RX_ON     = 2;
	localparam int C2_SEND_BRK  = 0;

	// ****************************************************************
	// reset values and timing
	// ****************************************************************
	localparam logic [7:0]  CTRL_RST     = 8'h00;
	localparam logic [7:0]  DIV_RST      = 8'h00;
	localparam logic [3:0]  OS_LAST      = 4'hF;   // 16 rx ticks per bit
	localparam logic [3:0]  OS_MID       = 4'h7;   // start bit checked mid-bit
	localparam logic [3:0]  FRAME_LEN8   = 4'hA;   // start + 8 + stop
	localparam logic [3:0]  FRAME_LEN9   = 4'hB;   // start + 9 + stop
	localparam logic [3:0]  MARK_LEN     = 4'h1;   // extra high bit after break

	typedef enum logic [1:0] {TXK_DATA, TXK_IDLE, TXK_BREAK, TXK_MARK} tx_kind_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_WAIT_HIGH} rx_state_t;

endpackage

// ### core/serial_core.sv
// Purpose: transmit and receive character path of an asynchronous NRZ serial port
// Assumes: register port strobes are one cycle long; serial_rx_pin is synchronous to clk
// Notes:   the cpu global interrupt mask is applied outside this block
//
// The strobed register port and the address map are this design's own decisions.

`timescale 1ns/1ps

// Overview of operation
// - word length 8 or 9 bits, both directions
// - transmit pin low during start bit
// - transmit pin high during stop bit
// - idle frame is a full frame of ones
// - all-zero frame received is flagged break
// - separate transmit and receive baud generators
// - ninth transmit bit taken from tx_ninth_bit
// - lsb first; write buffer feeds shift register
// - enabling transmitter sends idle frame first
// - empty flag clears by status access, data write
// - empty flag sets when buffer moves to shifter
// - empty flag requests interrupt when enabled
// - write while busy waits in buffer
// - write while idle starts frame at once
// - done flag sets after stop bit
// - done flag clears like empty flag
// - send-break repeats frame-length break frames
// - one high bit appended after last break
// - re-enable mid-frame sends idle after word
// - toggling enable discards buffered word
// - ninth received bit kept in rx_ninth_bit
// - receive lsb first into rx_buffer
// - pin idles high; released when both disabled
// - full flag sets per character, clears by sequence
module serial_core
	import serial_pkg::*;
(
	input  wire logic                         clk,
	input  wire logic                         rst,
	input  wire logic [serial_pkg::ADDR_W-1:0] addr,
	input  wire logic [serial_pkg::DATA_W-1:0] wdata,
	input  wire logic                         wr,
	input  wire logic                         rd,
	output logic      [serial_pkg::DATA_W-1:0] rdata,
	input  wire logic                         serial_rx_pin,
	output logic                              tx_pin,
	output logic                              tx_pin_oe,
	output logic                              irq
);
	import serial_pkg::*;

	// ****************************************************************
	// register port decode
	// ****************************************************************
	logic [7:0] serial_ctrl_one_r, serial_ctrl_two_r, tx_div_r, rx_div_r;
	logic       stat_seen_r;
	wire        rd_stat = rd && (addr == OFF_STATUS);
	wire        rd_data = rd && (addr == OFF_DATA);
	wire        wr_data = wr && (addr == OFF_DATA);
	wire        wr_c1   = wr && (addr == OFF_CTRL_ONE);
	wire        wr_c2   = wr && (addr == OFF_CTRL_TWO);
	wire        wr_txd  = wr && (addr == OFF_TX_DIV);
	wire        wr_rxd  = wr && (addr == OFF_RX_DIV);
	wire        tx_clr  = stat_seen_r && wr_data;
	wire        rx_clr  = stat_seen_r && rd_data;

	wire        word9   = serial_ctrl_one_r[C1_WORD9];
	wire        tx_ninth_bit = serial_ctrl_one_r[C1_TX_NINTH];
	wire        tx_on   = serial_ctrl_two_r[C2_TX_ON];
	wire        rx_on   = serial_ctrl_two_r[C2_RX_ON];
	wire        send_break_ctl = serial_ctrl_two_r[C2_SEND_BRK];
	wire [3:0]  frame_len = word9 ? FRAME_LEN9 : FRAME_LEN8;

	// control registers; rx_ninth_bit is overlaid on read, not stored here
	always_ff @(posedge clk) begin
		if (rst) begin
			serial_ctrl_one_r <= CTRL_RST;
			serial_ctrl_two_r <= CTRL_RST;
			tx_div_r          <= DIV_RST;
			rx_div_r          <= DIV_RST;
			stat_seen_r       <= 1'b0;
		end else begin
			if (wr_c1) serial_ctrl_one_r <= wdata;
			if (wr_c2) serial_ctrl_two_r <= wdata;
			if (wr_txd) tx_div_r <= wdata;
			if (wr_rxd) rx_div_r <= wdata;
			// first step of every clearing sequence; spent by any data access
			if (rd_stat) stat_seen_r <= 1'b1;
			else if (wr_data || rd_data) stat_seen_r <= 1'b0;
		end
	end

	// ****************************************************************
	// transmitter
	// ****************************************************************
	logic        tx_on_prev_r, tx_busy_r, tx_buf_full_r, idle_pend_r, brk_sent_r;
	logic        tx_empty_flag_r, tx_done_flag_r;
	logic [7:0]  tx_buffer_r;
	logic [10:0] tx_sh_r;
	logic [3:0]  tx_left_r;
	logic [11:0] tx_cnt_r;
	tx_kind_t    tx_kind_r;

	// own baud generator: one bit every 16*(div+1) clocks
	wire [11:0] tx_reload = {tx_div_r, 4'hF};
	wire        tx_tick   = (tx_cnt_r == 12'h000);
	wire        tx_on_rise = tx_on && !tx_on_prev_r;
	wire        tx_on_chg  = tx_on ^ tx_on_prev_r;
	wire        frame_end  = tx_busy_r && tx_tick && (tx_left_r == MARK_LEN);
	wire        boundary   = !tx_busy_r || frame_end;
	wire        ld_en      = boundary && tx_on;
	wire        idle_pend  = idle_pend_r || tx_on_rise;
	// a toggled enable throws the held word away
	wire        buf_avail  = (tx_buf_full_r && !tx_on_chg) || wr_data;
	wire [7:0]  tx_word    = wr_data ? wdata : tx_buffer_r;
	// selection order: break, closing mark, idle, data
	wire        ld_break   = ld_en && send_break_ctl;
	wire        ld_mark    = ld_en && !send_break_ctl && brk_sent_r;
	wire        ld_idle    = ld_en && !send_break_ctl && !brk_sent_r && idle_pend;
	wire        ld_data    = ld_en && !send_break_ctl && !brk_sent_r && !idle_pend
	                         && buf_avail;
	wire        ld_any     = ld_break || ld_mark || ld_idle || ld_data;
	wire        tx_done_set = frame_end && !ld_any;
	// frame image shifted out from bit 0: start low, data lsb first, stop high
	wire [10:0] data_frame = word9 ? {1'b1, tx_ninth_bit, tx_word, 1'b0}
	                               : {2'b11, tx_word, 1'b0};

	logic [10:0] tx_sh_nxt;
	logic [3:0]  tx_left_nxt;
	tx_kind_t    tx_kind_nxt;

	// frame loader and shifter
	always_comb begin
		tx_sh_nxt   = tx_sh_r;
		tx_left_nxt = tx_left_r;
		tx_kind_nxt = tx_kind_r;
		if (ld_break) begin
			tx_sh_nxt   = 11'h000;
			tx_left_nxt = frame_len;
			tx_kind_nxt = TXK_BREAK;
		end else if (ld_mark) begin
			tx_sh_nxt   = 11'h7FF;
			tx_left_nxt = MARK_LEN;
			tx_kind_nxt = TXK_MARK;
		end else if (ld_idle) begin
			tx_sh_nxt   = 11'h7FF;
			tx_left_nxt = frame_len;
			tx_kind_nxt = TXK_IDLE;
		end else if (ld_data) begin
			tx_sh_nxt   = data_frame;
			tx_left_nxt = frame_len;
			tx_kind_nxt = TXK_DATA;
		end else if (tx_busy_r && tx_tick) begin
			tx_sh_nxt   = {1'b1, tx_sh_r[10:1]};
			tx_left_nxt = tx_left_r - 4'h1;
		end
	end

	// restarting the divider on load keeps the first bit a full period long
	always_ff @(posedge clk) begin
		if (rst) tx_cnt_r <= 12'h000;
		else if (ld_any || tx_tick) tx_cnt_r <= tx_reload;
		else tx_cnt_r <= tx_cnt_r - 12'h001;
	end

	// frame state
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_sh_r   <= 11'h7FF;
			tx_left_r <= 4'h0;
			tx_kind_r <= TXK_IDLE;
			tx_busy_r <= 1'b0;
		end else begin
			tx_sh_r   <= tx_sh_nxt;
			tx_left_r <= tx_left_nxt;
			tx_kind_r <= tx_kind_nxt;
			tx_busy_r <= ld_any || (tx_busy_r && !frame_end);
		end
	end

	// buffer, pending idle and break memory
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_on_prev_r  <= 1'b0;
			tx_buffer_r   <= 8'h00;
			tx_buf_full_r <= 1'b0;
			idle_pend_r   <= 1'b0;
			brk_sent_r    <= 1'b0;
		end else begin
			tx_on_prev_r <= tx_on;
			if (wr_data && !ld_data) tx_buffer_r <= wdata;
			tx_buf_full_r <= (wr_data && !ld_data) ||
			                 (tx_buf_full_r && !tx_on_chg && !ld_data);
			idle_pend_r   <= idle_pend && !ld_idle;
			brk_sent_r    <= ld_break || (brk_sent_r && !ld_mark);
		end
	end

	// flags: the hardware set beats the software clear
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_empty_flag_r <= 1'b1;
			tx_done_flag_r  <= 1'b1;
		end else begin
			tx_empty_flag_r <= ld_data || tx_on_chg || (tx_empty_flag_r && !tx_clr);
			tx_done_flag_r  <= tx_done_set || (tx_done_flag_r && !tx_clr);
		end
	end

	// pin: high whenever no frame is on it, released when both halves are off
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_pin    <= 1'b1;
			tx_pin_oe <= 1'b0;
		end else begin
			tx_pin    <= tx_busy_r ? tx_sh_r[0] : 1'b1;
			tx_pin_oe <= tx_on || rx_on;
		end
	end

	// ****************************************************************
	// receiver
	// ****************************************************************
	rx_state_t  rx_st_r, rx_st_nxt;
	logic [7:0] rx_cnt_r, rx_buffer_r;
	logic [3:0] rx_phase_r, rx_phase_nxt, rx_bits_r, rx_bits_nxt;
	logic [8:0] rx_sh_r, rx_sh_nxt;
	logic       rx_done, rx_ninth_bit_r, rx_full_flag_r, overrun_r, break_flag_r;

	// own baud generator: 16 ticks per bit, one tick every div+1 clocks
	wire        rx_tick = (rx_cnt_r == 8'h00);
	wire [7:0]  rx_word = word9 ? rx_sh_r[7:0] : rx_sh_r[8:1];
	wire        rx_zero = (rx_word == 8'h00) && !(word9 && rx_sh_r[8]);

	always_ff @(posedge clk) begin
		if (rst || rx_tick) rx_cnt_r <= rx_div_r;
		else rx_cnt_r <= rx_cnt_r - 8'h01;
	end

	// oversampling receive sequencer
	always_comb begin
		rx_st_nxt    = rx_st_r;
		rx_phase_nxt = rx_phase_r;
		rx_bits_nxt  = rx_bits_r;
		rx_sh_nxt    = rx_sh_r;
		rx_done      = 1'b0;
		case (rx_st_r)
			RX_IDLE: begin
				rx_phase_nxt = 4'h0;
				if (!serial_rx_pin) rx_st_nxt = RX_START;
			end
			RX_START: if (rx_tick) begin
				rx_phase_nxt = rx_phase_r + 4'h1;
				if (rx_phase_r == OS_MID) begin
					// a start bit gone by mid-bit is taken as a glitch
					rx_st_nxt    = serial_rx_pin ? RX_IDLE : RX_DATA;
					rx_phase_nxt = 4'h0;
					rx_bits_nxt  = 4'h0;
				end
			end
			RX_DATA: if (rx_tick) begin
				rx_phase_nxt = rx_phase_r + 4'h1;
				if (rx_phase_r == OS_LAST) begin
					rx_sh_nxt   = {serial_rx_pin, rx_sh_r[8:1]};
					rx_bits_nxt = rx_bits_r + 4'h1;
					if (rx_bits_r == frame_len - 4'h3) rx_st_nxt = RX_STOP;
				end
			end
			RX_STOP: if (rx_tick) begin
				rx_phase_nxt = rx_phase_r + 4'h1;
				if (rx_phase_r == OS_LAST) begin
					rx_done   = 1'b1;
					rx_st_nxt = serial_rx_pin ? RX_IDLE : RX_WAIT_HIGH;
				end
			end
			// a held-low line must go high before another start is hunted
			RX_WAIT_HIGH: if (serial_rx_pin) rx_st_nxt = RX_IDLE;
			default: rx_st_nxt = RX_IDLE;
		endcase
		if (!rx_on) rx_st_nxt = RX_IDLE;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rx_st_r    <= RX_IDLE;
			rx_phase_r <= 4'h0;
			rx_bits_r  <= 4'h0;
			rx_sh_r    <= 9'h000;
		end else begin
			rx_st_r    <= rx_st_nxt;
			rx_phase_r <= rx_phase_nxt;
			rx_bits_r  <= rx_bits_nxt;
			rx_sh_r    <= rx_sh_nxt;
		end
	end

	// rx_buffer keeps the unread character on overrun; new one is dropped
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_buffer_r    <= 8'h00;
			rx_ninth_bit_r <= 1'b0;
			rx_full_flag_r <= 1'b0;
			overrun_r      <= 1'b0;
			break_flag_r   <= 1'b0;
		end else begin
			if (rx_done && !rx_full_flag_r) begin
				rx_buffer_r    <= rx_word;
				rx_ninth_bit_r <= rx_sh_r[8];
			end
			rx_full_flag_r <= rx_done || (rx_full_flag_r && !rx_clr);
			overrun_r      <= (rx_done && rx_full_flag_r) || (overrun_r && !rx_clr);
			break_flag_r   <= (rx_done && rx_zero && !serial_rx_pin)
			                  || (break_flag_r && !rx_clr);
		end
	end

	// ****************************************************************
	// read mux and interrupt
	// ****************************************************************
	logic [7:0] status_val, rd_mux;

	always_comb begin
		status_val              = 8'h00;
		status_val[ST_TX_EMPTY] = tx_empty_flag_r;
		status_val[ST_TX_DONE]  = tx_done_flag_r;
		status_val[ST_RX_FULL]  = rx_full_flag_r;
		status_val[ST_OVERRUN]  = overrun_r;
		status_val[ST_BREAK]    = break_flag_r;
		case (addr)
			OFF_STATUS:   rd_mux = status_val;
			OFF_DATA:     rd_mux = rx_buffer_r;
			OFF_CTRL_ONE: begin
				rd_mux              = serial_ctrl_one_r;
				rd_mux[C1_RX_NINTH] = rx_ninth_bit_r;
			end
			OFF_CTRL_TWO: rd_mux = serial_ctrl_two_r;
			OFF_TX_DIV:   rd_mux = tx_div_r;
			OFF_RX_DIV:   rd_mux = rx_div_r;
			default:      rd_mux = 8'h00;
		endcase
	end

	wire irq_nxt = (tx_empty_flag_r && serial_ctrl_two_r[C2_EMPTY_IE])
	            || (tx_done_flag_r && serial_ctrl_two_r[C2_DONE_IE])
	            || (rx_full_flag_r && serial_ctrl_two_r[C2_FULL_IE]);

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= 8'h00;
			irq   <= 1'b0;
		end else begin
			rdata <= rd ? rd_mux : 8'h00;
			irq   <= irq_nxt;
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// status read, one quiet cycle, then the data write that spends it
	sequence s_clear_by_write;
		rd_stat ##1 !(wr_data || rd_data) ##1 (wr_data && !tx_done_set);
	endsequence

	chk_start_bit_low: assert property (ld_data |-> ##2 !tx_pin)
		else $error("start bit not low");
	chk_stop_bit_high: assert property (
		(tx_busy_r && tx_kind_r == TXK_DATA && tx_left_r == MARK_LEN) |-> ##1 tx_pin)
		else $error("stop bit not high");
	chk_idle_pin_high: assert property (!tx_busy_r |-> ##1 tx_pin)
		else $error("idle pin not high");
	chk_empty_on_load: assert property (ld_data |=> tx_empty_flag_r)
		else $error("empty flag missing after load");
	chk_empty_clear_seq: assert property (
		(tx_clr && !ld_data && !tx_on_chg) |=> !tx_empty_flag_r)
		else $error("empty flag not cleared");
	chk_done_clear_seq: assert property (s_clear_by_write |=> !tx_done_flag_r)
		else $error("done flag not cleared");
	chk_done_after_stop: assert property (tx_done_set |=> tx_done_flag_r)
		else $error("done flag not set");
	chk_enable_idle: assert property (
		(tx_on_rise && !boundary && !wr_data) |=> idle_pend_r && !tx_buf_full_r)
		else $error("enable did not queue idle");
	chk_rx_full_set: assert property (rx_done |=> rx_full_flag_r ##1 1'b1)
		else $error("full flag not set");
	chk_irq_or: assert property (
		(rx_full_flag_r && serial_ctrl_two_r[C2_FULL_IE]) |=> irq)
		else $error("interrupt not raised");
	chk_break_mark: assert property (
		(brk_sent_r && ld_en && !send_break_ctl) |=> tx_kind_r == TXK_MARK ##1 tx_pin)
		else $error("no high bit after break");

endmodule // serial_core

// ### dv/serial_peer.sv
// Purpose: far-side serial equipment, sends frames to the core and decodes its transmit line
// Assumes: bit periods given in clk cycles; line_in already resolved with its pull-up
// Notes:   decoded frames are kept as {stop, data} with the data lsb at bit 0

`timescale 1ns/1ps

module serial_peer #(
	parameter int TX_BIT = 16,   // clk cycles per bit of the core transmitter
	parameter int RX_BIT = 32    // clk cycles per bit this model sends at
) (
	input  wire logic clk,
	input  wire logic line_in,
	input  wire logic word9,
	output logic      line_out
);
	logic [15:0] got_q[$];
	logic [15:0] v;
	int          nb;
	int          i;

	// ****************************************************************
	// line driver and frame decoder
	// ****************************************************************
	initial line_out = 1'b1;   // line idles at mark level

	// send one frame; the line returns to mark so a stop of 0 reads as a break
	task automatic send(input logic [15:0] data, input int nbits, input logic stop);
		int k;
		line_out <= 1'b0;
		repeat (RX_BIT) @(posedge clk);
		for (k = 0; k < nbits; k++) begin
			line_out <= data[k];
			repeat (RX_BIT) @(posedge clk);
		end
		line_out <= stop;
		repeat (RX_BIT) @(posedge clk);
		line_out <= 1'b1;
	endtask

	// mid-bit sampling; after a frame wait for mark so a break is one record
	initial begin
		forever begin
			@(posedge clk);
			if (line_in === 1'b0) begin
				nb = word9 ? 9 : 8;
				repeat (TX_BIT / 2) @(posedge clk);
				v = '0;
				for (i = 0; i <= nb; i++) begin
					repeat (TX_BIT) @(posedge clk);
					v[i] = line_in;
				end
				got_q.push_back(v);
				while (line_in !== 1'b1) @(posedge clk);
			end
		end
	end
endmodule // serial_peer

// ### dv/tb_async_serial_tx_rx_core.sv
// Purpose: self-checking bench for the serial character path
// Assumes: tx divisor 0 (16 clk per bit), rx divisor 1 (32 clk per bit)
// Notes:   expected frames kept in a queue and matched against the peer decoder

`timescale 1ns/1ps

module tb_async_serial_tx_rx_core;
	import serial_pkg::*;

	localparam logic [7:0] ON2 = 8'h0C;   // tx_on and rx_on

	logic                clk;
	logic                rst;
	logic [ADDR_W-1:0]   addr;
	logic [DATA_W-1:0]   wdata;
	logic                wr;
	logic                rd;
	logic [DATA_W-1:0]   rdata;
	logic                rx_line;
	logic                tx_pin;
	logic                tx_pin_oe;
	logic                irq;
	logic                word9;
	wire                 tx_line = tx_pin_oe ? tx_pin : 1'b1;   // pull-up when released
	logic [15:0]         exp_q[$];
	logic [31:0]         rnd_r;
	logic [7:0]          r;
	logic [7:0]          d0;
	logic [7:0]          d1;
	int                  error_cnt;
	int                  check_count;
	int                  gap;
	int                  n;
	int                  cyc;

	serial_core dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .serial_rx_pin(rx_line), .tx_pin(tx_pin), .tx_pin_oe(tx_pin_oe),
		.irq(irq));

	// peer defaults already match tx divisor 0 and rx divisor 1
	serial_peer peer (.clk(clk), .line_in(tx_line),
		.word9(word9), .line_out(rx_line));

	// ****************************************************************
	// clock, timeout and reporting
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// whole run needs about 4.5k cycles; a hang is cut well above that
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			$display("[FAIL] timeout expected end seen none");
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// one step of the 32-bit lfsr that feeds every random field
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk_reg(input string name, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic chk_frame(input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] frame expected %h seen %h", e, g);
		end
	endtask

	task automatic end_test(input string name);
		$display("test %s done", name);
	endtask

	// ****************************************************************
	// register port and stream helpers
	// ****************************************************************
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1 d = rdata;
	endtask

	// status access then data write; s returns the status seen
	task automatic arm_write(input logic [7:0] d, output logic [7:0] s);
		rd_reg(OFF_STATUS, s);
		wr_reg(OFF_DATA, d);
	endtask

	// bounded wait for one decoded frame; cycles waited go back for gap checks
	task automatic wait_frame(output int w);
		logic [15:0] g;
		w = 0;
		while (peer.got_q.size() == 0 && w < 2000) begin
			@(posedge clk);
			w++;
		end
		g = (peer.got_q.size() > 0) ? peer.got_q.pop_front() : 16'hFFFF;
		chk_frame(exp_q.pop_front(), g);
	endtask

	task automatic rx_word(input logic [15:0] v, input int nb);
		logic [7:0] s;
		peer.send(v, nb, 1'b1);
		rd_reg(OFF_STATUS, s);
		chk_reg("rx_full", 8'h01, {7'h0, s[ST_RX_FULL]});
		rd_reg(OFF_DATA, s);
		chk_reg("rx_data", v[7:0], s);
		rd_reg(OFF_CTRL_ONE, s);
		if (nb == 9)
			chk_reg("rx_ninth", {7'h0, v[8]}, {7'h0, s[C1_RX_NINTH]});
		rd_reg(OFF_STATUS, s);
		chk_reg("rx_clear", 8'h00, {7'h0, s[ST_RX_FULL]});
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		rst = 1'b1;
		addr = '0;
		wdata = '0;
		wr = 1'b0;
		rd = 1'b0;
		word9 = 1'b0;
		rnd_r = 32'h5F8F1F46;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd_reg(OFF_STATUS, r);
		chk_reg("status", 8'hC0, r);
		rd_reg(OFF_CTRL_TWO, r);
		chk_reg("ctrl_two", CTRL_RST, r);
		rd_reg(3'h6, r);
		chk_reg("unmapped", 8'h00, r);
		chk_reg("oe", 8'h00, {7'h0, tx_pin_oe});
		chk_reg("pin", 8'h01, {7'h0, tx_pin});
		end_test("reset");
		// enabling sends an idle frame ahead of the first word
		wr_reg(OFF_RX_DIV, 8'h01);
		wr_reg(OFF_CTRL_TWO, ON2);
		arm_write(8'h3C, r);
		rd_reg(OFF_STATUS, r);
		chk_reg("oe", 8'h01, {7'h0, tx_pin_oe});
		chk_reg("empty", 8'h00, {7'h0, r[ST_TX_EMPTY]});
		exp_q.push_back(16'h013C);
		wait_frame(gap);
		chk_reg("idle_gap", 8'h01, {7'h0, gap >= 250});
		repeat (16) @(posedge clk);
		rd_reg(OFF_STATUS, r);
		chk_reg("done", 8'hC0, r);
		end_test("idle_first");
		// random back-to-back words: direct load then buffered
		for (n = 0; n < 3; n++) begin
			rnd_r = lfsr_next(rnd_r);
			d0 = rnd_r[7:0];
			d1 = rnd_r[15:8];
			arm_write(d0, r);
			arm_write(d1, r);
			chk_reg("direct", 8'h80, r);
			rd_reg(OFF_STATUS, r);
			chk_reg("buffered", 8'h00, r);
			exp_q.push_back({8'h01, d0});
			exp_q.push_back({8'h01, d1});
			wait_frame(gap);
			wait_frame(gap);
			repeat (16) @(posedge clk);
		end
		end_test("back_to_back");
		// ninth bit from the control register, both values
		word9 <= 1'b1;
		for (n = 0; n < 2; n++) begin
			wr_reg(OFF_CTRL_ONE, (n == 1) ? 8'h50 : 8'h10);
			arm_write(8'hA5, r);
			exp_q.push_back({6'h00, 1'b1, n[0], 8'hA5});
			wait_frame(gap);
			repeat (16) @(posedge clk);
			rnd_r = lfsr_next(rnd_r);
			rx_word({7'h00, rnd_r[8:0]}, 9);
		end
		wr_reg(OFF_CTRL_ONE, 8'h00);
		word9 <= 1'b0;
		rnd_r = lfsr_next(rnd_r);
		rx_word({8'h00, rnd_r[7:0]}, 8);
		end_test("word_length");
		// received break, then sent break with the closing mark
		peer.send(16'h0000, 8, 1'b0);
		rd_reg(OFF_STATUS, r);
		chk_reg("rx_break", 8'h01, {7'h0, r[ST_BREAK]});
		rd_reg(OFF_DATA, r);
		rd_reg(OFF_STATUS, r);
		chk_reg("break_clr", 8'h00, {7'h0, r[ST_BREAK]});
		wr_reg(OFF_CTRL_TWO, ON2 | 8'h01);
		exp_q.push_back(16'h0000);
		wait_frame(gap);
		wr_reg(OFF_CTRL_TWO, ON2);
		arm_write(8'h96, r);
		exp_q.push_back(16'h0196);
		wait_frame(gap);
		end_test("break");
		// enable toggle drops the buffered word and inserts an idle frame
		repeat (20) @(posedge clk);
		arm_write(8'h11, r);
		arm_write(8'h22, r);
		wr_reg(OFF_CTRL_TWO, 8'h04);
		wr_reg(OFF_CTRL_TWO, ON2);
		rd_reg(OFF_STATUS, r);
		chk_reg("empty_toggle", 8'h01, {7'h0, r[ST_TX_EMPTY]});
		arm_write(8'h33, r);
		exp_q.push_back(16'h0111);
		exp_q.push_back(16'h0133);
		wait_frame(gap);
		wait_frame(gap);
		chk_reg("idle_after", 8'h01, {7'h0, gap >= 250});
		end_test("toggle");
		// interrupt request follows each enabled flag
		repeat (20) @(posedge clk);
		for (n = 7; n >= 5; n--) begin
			wr_reg(OFF_CTRL_TWO, ON2 | (8'h01 << n));
			repeat (2) @(posedge clk);
			#1 chk_reg("irq", {7'h0, n != 5}, {7'h0, irq});
		end
		peer.send(16'h005C, 8, 1'b1);
		#1 chk_reg("irq_full", 8'h01, {7'h0, irq});
		rd_reg(OFF_STATUS, r);
		rd_reg(OFF_DATA, r);
		repeat (2) @(posedge clk);
		#1 chk_reg("irq_clr", 8'h00, {7'h0, irq});
		end_test("irq");
		wr_reg(OFF_CTRL_TWO, 8'h00);
		repeat (2) @(posedge clk);
		#1 chk_reg("oe_off", 8'h00, {7'h0, tx_pin_oe});
		chk_reg("pin_off", 8'h01, {7'h0, tx_pin});
		end_test("disable");
		tally_and_finish();
	end
endmodule // tb_async_serial_tx_rx_core
